// file: hw/fpt_pkg.sv
package fpt_pkg;

   // ---------------------------------------------------------------
   // Register indices behind the index/data port pair
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_ALT_DIV  = 8'h24;
   localparam logic [7:0] IDX_LOCK_TWO = 8'h27;
   localparam logic [7:0] IDX_FEAT_3   = 8'h29;
   localparam logic [7:0] IDX_PC_TWO   = 8'h33;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_ALT_DIV  = 8'h3c;
   localparam logic [7:0] RST_LOCK_TWO = 8'h00;
   localparam logic [7:0] RST_FEAT_3   = 8'h00;
   localparam logic [7:0] RST_PC_TWO   = 8'h00;
   localparam logic [7:0] RST_INDEX    = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int LOCK_VDE_BIT  = 6;
   localparam int LOCK_HDE_BIT  = 4;
   localparam int LOCK_EXP_HI   = 1;
   localparam int LOCK_EXP_LO   = 0;
   localparam int FC3_AVE_BIT   = 7;
   localparam int FC3_DITH_HI   = 6;
   localparam int FC3_LPFP_BIT  = 5;
   localparam int FC3_PIX_OFF   = 4;
   localparam int FC3_SYNC_OFF  = 3;
   localparam int FC3_DITH_LO   = 2;
   localparam int PC2_RES_HI    = 7;
   localparam int PC2_STN_HI    = 6;
   localparam int PC2_STN_LO    = 5;
   localparam int PC2_RES_LO    = 4;
   localparam int PC2_LCD4_BIT  = 3;
   localparam int PC2_PWM_BIT   = 2;
   localparam int PC2_REF_TWO   = 1;
   localparam int PC2_REF_OWN   = 0;

   // ---------------------------------------------------------------
   // Display-timing register indices guarded by the lock
   // ---------------------------------------------------------------
   localparam logic [7:0] CRT_IDX_HDE   = 8'h01;
   localparam logic [7:0] CRT_IDX_OVF   = 8'h07;
   localparam logic [7:0] CRT_IDX_VDE   = 8'h12;
   localparam logic [7:0] OVF_LOCK_BITS = 8'h42;

   // ---------------------------------------------------------------
   // Alternation counter width in bits, and mono period in lines
   // ---------------------------------------------------------------
   localparam int         ALT_CNT_W      = 10;
   localparam logic [9:0] ALT_MONO_LINES = 10'd480;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FPT_RES_640  = 2'b00,
      FPT_RES_RSVD = 2'b01,
      FPT_RES_1024 = 2'b10,
      FPT_RES_800  = 2'b11
   } fpt_res_t;

   typedef enum logic [1:0] {
      FPT_EXP_NONE        = 2'b00,
      FPT_EXP_THREE_BELOW = 2'b01,
      FPT_EXP_SPLIT       = 2'b11
   } fpt_exp_t;

endpackage : fpt_pkg

// file: hw/fpt_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a change counts once stages two and three agree
module fpt_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   // Pin side
   input  wire logic [W-1:0] pin_i,
   // Clock domain side
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] out_r;
   logic [W-1:0] out_nxt;

   always_comb begin
      out_nxt = out_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            out_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         out_r <= '0;
      end else begin
         s1_r  <= pin_i;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign sync_o = out_r;

endmodule : fpt_pin_sync

`default_nettype wire

// file: hw/fpt_alt_gen.sv
`timescale 1ns/1ps
`default_nettype none

// Square wave that toggles after half_i line strobes
module fpt_alt_gen
   import fpt_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   // Line timing
   input  wire logic                 line_stb_i,
   input  wire logic [ALT_CNT_W-1:0] half_i,
   // Output
   output logic                      alt_o
);

   logic [ALT_CNT_W-1:0] cnt_r;
   logic [ALT_CNT_W-1:0] cnt_nxt;
   logic                 alt_r;
   logic                 alt_nxt;

   // Zero half period (reserved divisor) freezes the wave
   always_comb begin
      cnt_nxt = cnt_r;
      alt_nxt = alt_r;
      if (line_stb_i && (half_i != '0)) begin
         if (cnt_r >= half_i - 1'b1) begin
            cnt_nxt = '0;
            alt_nxt = ~alt_r;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
         alt_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         alt_r <= alt_nxt;
      end
   end

   assign alt_o = alt_r;

endmodule : fpt_alt_gen

`default_nettype wire

// file: hw/fpt_panel_ctrl.sv
// Contract
// - Color alternation period is four times divisor lines
// - Monochrome alternation period fixed at 480 lines
// - Divisor resets to 3Ch, 240-line period
// - Alternation drives shared pin when enabled
// - Alternation output has 50% duty cycle
// - Lock bit 6 clear permits vertical end writes
// - Lock bit 4 clear permits horizontal end writes
// - Enhanced expansion acts only in 400-line text
// - Expansion codes: none, three below, split
// - External DAC mode turns pixel pins into inputs
// - Bit 5 copies syncs onto line/frame pulses
// - Bit 4 holds pixel clock low; blank and video low only when CRT-only
// - Bit 3 holds both syncs inactive low
// - Dither mode from feature bits 6 and 2
// - Panel resolution from control two bits 7,4
// - STN type from control two bits 6:5
// - Bit 3 selects 4-bit or 8-bit LCD
// - Bit 2 selects FRM or PWM shading
// - Bit 1 selects one or two refreshes
// - Bit 0 hands refresh control to bit 1
`timescale 1ns/1ps
`default_nettype none

module fpt_panel_ctrl
   import fpt_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Host index/data port
   input  wire logic       host_wr_i,
   input  wire logic       host_sel_data_i,
   input  wire logic [7:0] host_wdata_i,
   output logic      [7:0] host_rdata_o,
   // Panel control one fields and mode status
   input  wire logic       alt_on_pin_en_i,
   input  wire logic [1:0] vexp_sel_i,
   input  wire logic       panel_color_i,
   input  wire logic       text_400_i,
   input  wire logic       crt_only_i,
   // Internal timing and pixel sources
   input  wire logic       line_stb_i,
   input  wire logic       hsync_i,
   input  wire logic       vsync_i,
   input  wire logic       line_pulse_i,
   input  wire logic       frame_pulse_i,
   input  wire logic       pclk_i,
   input  wire logic       blank_i,
   input  wire logic [7:0] video_pixel_bus_i,
   // Display-timing register write guard
   input  wire logic       crt_wr_i,
   input  wire logic [7:0] crt_wr_index_i,
   output logic            crt_wr_en_o,
   output logic      [7:0] crt_wr_bits_o,
   // Sync and panel pulse pins
   output logic            hsync_o,
   output logic            vsync_o,
   output logic            line_pulse_o,
   output logic            frame_pulse_o,
   output logic            alternation_blank_pin_o,
   // Two-way pixel pins
   input  wire logic       pclk_pin_i,
   output logic            pclk_pin_o,
   output logic            pclk_pin_oe_n_o,
   input  wire logic       blank_pin_i,
   output logic            blank_pin_o,
   output logic            blank_pin_oe_n_o,
   input  wire logic [7:0] video_pixel_pins_i,
   output logic      [7:0] video_pixel_pins_o,
   output logic            video_pixel_pins_oe_n_o,
   // Palette DAC feed
   output logic            dac_pclk_o,
   output logic            dac_blank_o,
   output logic      [7:0] dac_video_o,
   // Decoded panel configuration
   output logic      [1:0] enh_vexp_o,
   output logic      [1:0] vexp_sel_o,
   output logic      [1:0] tft_dither_sel_o,
   output logic      [1:0] panel_res_o,
   output logic      [1:0] stn_type_o,
   output logic            lcd_4bit_o,
   output logic            shade_pwm_o,
   output logic            refresh_own_o,
   output logic      [1:0] refresh_per_line_o
);

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] index_r;
   logic [7:0] index_nxt;
   logic [7:0] alt_div_r;
   logic [7:0] alt_div_nxt;
   logic [7:0] lock_two_r;
   logic [7:0] lock_two_nxt;
   logic [7:0] feat_3_r;
   logic [7:0] feat_3_nxt;
   logic [7:0] pc_two_r;
   logic [7:0] pc_two_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       data_wr;

   assign data_wr = host_wr_i && host_sel_data_i;

   // Reserved bits are stored as written; the feature reserved pair relies on host
   always_comb begin
      index_nxt    = index_r;
      alt_div_nxt  = alt_div_r;
      lock_two_nxt = lock_two_r;
      feat_3_nxt   = feat_3_r;
      pc_two_nxt   = pc_two_r;
      if (host_wr_i && !host_sel_data_i) begin
         index_nxt = host_wdata_i;
      end
      if (data_wr) begin
         case (index_r)
            IDX_ALT_DIV:  alt_div_nxt  = host_wdata_i;
            IDX_LOCK_TWO: lock_two_nxt = host_wdata_i;
            IDX_FEAT_3:   feat_3_nxt   = host_wdata_i;
            IDX_PC_TWO:   pc_two_nxt   = host_wdata_i;
            default:      index_nxt    = index_r;
         endcase
      end
   end

   // Read data follows the current index; unmapped indices read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (!host_sel_data_i) begin
         rdata_nxt = index_nxt;
      end else begin
         case (index_r)
            IDX_ALT_DIV:  rdata_nxt = alt_div_nxt;
            IDX_LOCK_TWO: rdata_nxt = lock_two_nxt;
            IDX_FEAT_3:   rdata_nxt = feat_3_nxt;
            IDX_PC_TWO:   rdata_nxt = pc_two_nxt;
            default:      rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         index_r    <= RST_INDEX;
         alt_div_r  <= RST_ALT_DIV;
         lock_two_r <= RST_LOCK_TWO;
         feat_3_r   <= RST_FEAT_3;
         pc_two_r   <= RST_PC_TWO;
         rdata_r    <= 8'h00;
      end else begin
         index_r    <= index_nxt;
         alt_div_r  <= alt_div_nxt;
         lock_two_r <= lock_two_nxt;
         feat_3_r   <= feat_3_nxt;
         pc_two_r   <= pc_two_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   assign host_rdata_o = rdata_r;

   // ---------------------------------------------------------------
   // Alternation generator
   // ---------------------------------------------------------------
   logic [ALT_CNT_W-1:0] alt_half;
   logic                 alt_wave;

   // Half period in lines: twice the divisor, or half of the fixed mono interval
   always_comb begin
      if (panel_color_i) begin
         alt_half = {1'b0, alt_div_r, 1'b0};
      end else begin
         alt_half = ALT_MONO_LINES >> 1;
      end
   end

   fpt_alt_gen u_alt_gen (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .line_stb_i (line_stb_i),
      .half_i     (alt_half),
      .alt_o      (alt_wave)
   );

   // ---------------------------------------------------------------
   // External DAC pin inputs
   // ---------------------------------------------------------------
   logic [9:0] ext_pix;
   logic       ave_on;

   assign ave_on = feat_3_r[FC3_AVE_BIT];

   fpt_pin_sync #(
      .W (10)
   ) u_ext_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({pclk_pin_i, blank_pin_i, video_pixel_pins_i}),
      .sync_o    (ext_pix)
   );

   // ---------------------------------------------------------------
   // Write guard for display-end registers
   // ---------------------------------------------------------------
   always_comb begin
      crt_wr_en_o   = crt_wr_i;
      crt_wr_bits_o = 8'hff;
      case (crt_wr_index_i)
         CRT_IDX_HDE: begin
            crt_wr_en_o   = crt_wr_i && !lock_two_r[LOCK_HDE_BIT];
            crt_wr_bits_o = lock_two_r[LOCK_HDE_BIT] ? 8'h00 : 8'hff;
         end
         CRT_IDX_VDE: begin
            crt_wr_en_o   = crt_wr_i && !lock_two_r[LOCK_VDE_BIT];
            crt_wr_bits_o = lock_two_r[LOCK_VDE_BIT] ? 8'h00 : 8'hff;
         end
         CRT_IDX_OVF: begin
            // Only the two display-end bits are frozen; the rest stay writable
            crt_wr_bits_o = lock_two_r[LOCK_VDE_BIT] ? ~OVF_LOCK_BITS : 8'hff;
         end
         default: crt_wr_bits_o = 8'hff;
      endcase
   end

   // ---------------------------------------------------------------
   // Pin outputs
   // ---------------------------------------------------------------
   logic       hs_nxt;
   logic       vs_nxt;
   logic       lp_nxt;
   logic       fp_nxt;
   logic       altb_nxt;
   logic       pclk_nxt;
   logic       blank_nxt;
   logic [7:0] video_nxt;
   logic [9:0] dac_nxt;
   logic       hs_r;
   logic       vs_r;
   logic       lp_r;
   logic       fp_r;
   logic       altb_r;
   logic       pclk_r;
   logic       blank_r;
   logic [7:0] video_r;
   logic [9:0] dac_r;
   logic       oe_n_r;
   logic       vid_off;

   assign vid_off = feat_3_r[FC3_PIX_OFF] && crt_only_i;

   always_comb begin
      hs_nxt    = feat_3_r[FC3_SYNC_OFF] ? 1'b0 : hsync_i;
      vs_nxt    = feat_3_r[FC3_SYNC_OFF] ? 1'b0 : vsync_i;
      lp_nxt    = feat_3_r[FC3_LPFP_BIT] ? hsync_i : line_pulse_i;
      fp_nxt    = feat_3_r[FC3_LPFP_BIT] ? vsync_i : frame_pulse_i;
      pclk_nxt  = feat_3_r[FC3_PIX_OFF] ? 1'b0 : pclk_i;
      blank_nxt = vid_off ? 1'b0 : blank_i;
      video_nxt = vid_off ? 8'h00 : video_pixel_bus_i;
      // Shared pin carries blank unless the alternation signal is routed to it
      altb_nxt  = alt_on_pin_en_i ? alt_wave : blank_nxt;
      // External source feeds the palette through the synchronisers
      dac_nxt   = ave_on ? ext_pix : {pclk_i, blank_i, video_pixel_bus_i};
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hs_r    <= 1'b0;
         vs_r    <= 1'b0;
         lp_r    <= 1'b0;
         fp_r    <= 1'b0;
         altb_r  <= 1'b0;
         pclk_r  <= 1'b0;
         blank_r <= 1'b0;
         video_r <= 8'h00;
         dac_r   <= 10'h000;
         oe_n_r  <= 1'b0;
      end else begin
         hs_r    <= hs_nxt;
         vs_r    <= vs_nxt;
         lp_r    <= lp_nxt;
         fp_r    <= fp_nxt;
         altb_r  <= altb_nxt;
         pclk_r  <= pclk_nxt;
         blank_r <= blank_nxt;
         video_r <= video_nxt;
         dac_r   <= dac_nxt;
         oe_n_r  <= ave_on;
      end
   end

   assign hsync_o                 = hs_r;
   assign vsync_o                 = vs_r;
   assign line_pulse_o            = lp_r;
   assign frame_pulse_o           = fp_r;
   assign alternation_blank_pin_o = altb_r;
   assign pclk_pin_o              = pclk_r;
   assign blank_pin_o             = blank_r;
   assign video_pixel_pins_o      = video_r;
   assign pclk_pin_oe_n_o         = oe_n_r;
   assign blank_pin_oe_n_o        = oe_n_r;
   assign video_pixel_pins_oe_n_o = oe_n_r;
   assign dac_pclk_o              = dac_r[9];
   assign dac_blank_o             = dac_r[8];
   assign dac_video_o             = dac_r[7:0];

   // ---------------------------------------------------------------
   // Decoded configuration
   // ---------------------------------------------------------------
   logic [1:0] exp_nxt;
   logic [1:0] exp_r;

   // Enhanced code only counts in 400-line text with plain expansion selected
   always_comb begin
      exp_nxt = FPT_EXP_NONE;
      if (text_400_i && (vexp_sel_i != 2'b00) && lock_two_r[LOCK_EXP_LO]) begin
         exp_nxt = lock_two_r[LOCK_EXP_HI] ? FPT_EXP_SPLIT : FPT_EXP_THREE_BELOW;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         exp_r <= FPT_EXP_NONE;
      end else begin
         exp_r <= exp_nxt;
      end
   end

   assign enh_vexp_o         = exp_r;
   assign vexp_sel_o         = vexp_sel_i;
   assign tft_dither_sel_o   = {feat_3_r[FC3_DITH_HI], feat_3_r[FC3_DITH_LO]};
   assign panel_res_o        = {pc_two_r[PC2_RES_HI], pc_two_r[PC2_RES_LO]};
   assign stn_type_o         = {pc_two_r[PC2_STN_HI], pc_two_r[PC2_STN_LO]};
   assign lcd_4bit_o         = pc_two_r[PC2_LCD4_BIT];
   assign shade_pwm_o        = pc_two_r[PC2_PWM_BIT];
   assign refresh_own_o      = pc_two_r[PC2_REF_OWN];
   // Zero means the CRT controller decides the count
   assign refresh_per_line_o = !pc_two_r[PC2_REF_OWN] ? 2'd0 :
                               (pc_two_r[PC2_REF_TWO] ? 2'd2 : 2'd1);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [ALT_CNT_W-1:0] seen_r;
   logic                 cfg_ok_r;
   logic                 alt_d_r;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         seen_r   <= '0;
         cfg_ok_r <= 1'b0;
         alt_d_r  <= 1'b0;
      end else begin
         alt_d_r <= alt_wave;
         if (alt_wave != alt_d_r) begin
            seen_r   <= {{(ALT_CNT_W-1){1'b0}}, line_stb_i};
            cfg_ok_r <= 1'b1;
         end else begin
            seen_r <= seen_r + {{(ALT_CNT_W-1){1'b0}}, line_stb_i};
            if (alt_half != u_alt_gen.half_i || $changed(alt_half)) begin
               cfg_ok_r <= 1'b0;
            end
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   alt_half_period_a : assert property (
      (alt_wave != alt_d_r) && cfg_ok_r && $stable(alt_half) |-> seen_r == alt_half)
      else $error("alternation half period wrong");

   mono_interval_a : assert property (
      !panel_color_i |-> alt_half == ALT_MONO_LINES / 2)
      else $error("mono alternation interval wrong");

   alt_pin_a : assert property (
      alt_on_pin_en_i |=> alternation_blank_pin_o == $past(alt_wave))
      else $error("alternation not on shared pin");

   vde_lock_a : assert property (
      crt_wr_i && crt_wr_index_i == CRT_IDX_VDE && lock_two_r[LOCK_VDE_BIT]
      |-> !crt_wr_en_o)
      else $error("locked vertical end written");

   hde_lock_a : assert property (
      crt_wr_i && crt_wr_index_i == CRT_IDX_HDE && !lock_two_r[LOCK_HDE_BIT]
      |-> crt_wr_en_o && crt_wr_bits_o == 8'hff)
      else $error("unlocked horizontal end refused");

   exp_gate_a : assert property (
      !text_400_i |=> enh_vexp_o == FPT_EXP_NONE)
      else $error("enhanced expansion outside text mode");

   ave_dir_a : assert property (
      data_wr && index_r == IDX_FEAT_3 && host_wdata_i[FC3_AVE_BIT] |=> ##1
      pclk_pin_oe_n_o && blank_pin_oe_n_o && video_pixel_pins_oe_n_o)
      else $error("pixel pins still driven in DAC access");

   lp_force_a : assert property (
      feat_3_r[FC3_LPFP_BIT] |=> line_pulse_o == $past(hsync_i)
      && frame_pulse_o == $past(vsync_i))
      else $error("line/frame pulse not following syncs");

   pclk_off_a : assert property (
      feat_3_r[FC3_PIX_OFF] [*2] |-> !pclk_pin_o)
      else $error("pixel clock not held low");

   sync_off_a : assert property (
      feat_3_r[FC3_SYNC_OFF] |=> !hsync_o && !vsync_o)
      else $error("syncs not held low");

   readback_a : assert property (
      data_wr && index_r == IDX_PC_TWO |=> host_sel_data_i && !host_wr_i
      && index_r == IDX_PC_TWO
      |=> host_rdata_o == $past(host_wdata_i, 2))
      else $error("register readback differs from write");

endmodule : fpt_panel_ctrl

`default_nettype wire

// file: bench/fpt_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side video extender: drives the pixel pins only while the device lets go
module fpt_far_side #(
   parameter int W = 1
) (
   // Clock
   input  wire logic         clk_i,
   // Device side of the pin
   input  wire logic         oe_n_i,
   input  wire logic [W-1:0] dev_i,
   // Wire level seen by everyone
   output logic      [W-1:0] pin_o
);
   logic [W-1:0] pat_r = '0;

   // Pattern moves every cycle so a stale level is never taken for data
   always_ff @(posedge clk_i) begin
      pat_r <= pat_r + W'(8'h3b);
   end

   assign pin_o = oe_n_i ? pat_r : dev_i;
endmodule : fpt_far_side
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import fpt_pkg::*;
   logic clk_i, sys_rst_i, host_wr_i, host_sel_data_i, alt_on_pin_en_i, panel_color_i;
   logic text_400_i, crt_only_i, line_stb_i, hsync_i, vsync_i, line_pulse_i;
   logic frame_pulse_i, pclk_i, blank_i, crt_wr_i;
   logic [7:0] host_wdata_i, video_pixel_bus_i, crt_wr_index_i;
   logic [1:0] vexp_sel_i, ln;
   wire logic hsync_o, vsync_o, line_pulse_o, frame_pulse_o, alternation_blank_pin_o;
   wire logic pclk_pin_o, pclk_pin_oe_n_o, blank_pin_oe_n_o, video_pixel_pins_oe_n_o;
   wire logic crt_wr_en_o, lcd_4bit_o, shade_pwm_o, pc_w, bl_w, bo_w, ro_w;
   wire logic [1:0] vs_w;
   wire logic [7:0] host_rdata_o, crt_wr_bits_o, vd_w, vo_w;
   wire logic [1:0] enh_vexp_o, panel_res_o, stn_type_o, tft_dither_sel_o, refresh_per_line_o;
   int mismatches, compares;
   logic [7:0] m [logic [7:0]];
   logic [7:0] lk [3] = '{8'h00, 8'h53, 8'h51};
   logic [7:0] ci [3] = '{8'h01, 8'h12, 8'h07};
   logic [7:0] fv [4] = '{8'h00, 8'h08, 8'h10, 8'h20};
   logic [7:0] v, f;

   fpt_panel_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_wr_i(host_wr_i),
      .host_sel_data_i(host_sel_data_i), .host_wdata_i(host_wdata_i),
      .host_rdata_o(host_rdata_o), .alt_on_pin_en_i(alt_on_pin_en_i), .vexp_sel_i(vexp_sel_i),
      .panel_color_i(panel_color_i), .text_400_i(text_400_i), .crt_only_i(crt_only_i),
      .line_stb_i(line_stb_i), .hsync_i(hsync_i), .vsync_i(vsync_i),
      .line_pulse_i(line_pulse_i), .frame_pulse_i(frame_pulse_i), .pclk_i(pclk_i),
      .blank_i(blank_i), .video_pixel_bus_i(video_pixel_bus_i), .crt_wr_i(crt_wr_i),
      .crt_wr_index_i(crt_wr_index_i), .crt_wr_en_o(crt_wr_en_o),
      .crt_wr_bits_o(crt_wr_bits_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
      .line_pulse_o(line_pulse_o), .frame_pulse_o(frame_pulse_o),
      .alternation_blank_pin_o(alternation_blank_pin_o), .pclk_pin_i(pc_w),
      .pclk_pin_o(pclk_pin_o), .pclk_pin_oe_n_o(pclk_pin_oe_n_o), .blank_pin_i(bl_w),
      .blank_pin_o(bo_w), .blank_pin_oe_n_o(blank_pin_oe_n_o), .video_pixel_pins_i(vd_w),
      .video_pixel_pins_o(vo_w), .video_pixel_pins_oe_n_o(video_pixel_pins_oe_n_o),
      .dac_pclk_o(), .dac_blank_o(), .dac_video_o(), .enh_vexp_o(enh_vexp_o),
      .vexp_sel_o(vs_w), .tft_dither_sel_o(tft_dither_sel_o), .panel_res_o(panel_res_o),
      .stn_type_o(stn_type_o), .lcd_4bit_o(lcd_4bit_o), .shade_pwm_o(shade_pwm_o),
      .refresh_own_o(ro_w), .refresh_per_line_o(refresh_per_line_o));
   fpt_far_side #(.W(1)) fs_pc (.clk_i(clk_i), .oe_n_i(pclk_pin_oe_n_o), .dev_i(pclk_pin_o),
      .pin_o(pc_w));
   fpt_far_side #(.W(1)) fs_bl (.clk_i(clk_i), .oe_n_i(blank_pin_oe_n_o), .dev_i(bo_w),
      .pin_o(bl_w));
   fpt_far_side #(.W(8)) fs_vd (.clk_i(clk_i), .oe_n_i(video_pixel_pins_oe_n_o),
      .dev_i(vo_w), .pin_o(vd_w));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Sources change every cycle; a line strobe every fourth cycle keeps runs short
   always @(posedge clk_i) begin
      #1;
      {hsync_i, vsync_i, line_pulse_i, frame_pulse_i, pclk_i, blank_i,
       video_pixel_bus_i} <= 14'($urandom);
      ln <= ln + 2'h1;
      line_stb_i <= (ln == 2'h3);
   end

   task cmp(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp

   task wr(input logic s, input logic [7:0] d);
      host_wr_i <= 1'b1;
      host_sel_data_i <= s;
      host_wdata_i <= d;
      @(posedge clk_i) #1 host_wr_i <= 1'b0;
      @(posedge clk_i) #1;
   endtask : wr

   task rw(input logic [7:0] i, input logic [7:0] d);
      wr(1'b0, i);
      wr(1'b1, d);
      if (m.exists(i)) m[i] = d;
   endtask : rw

   task rd(input logic [7:0] i);
      wr(1'b0, i);
      host_sel_data_i <= 1'b1;
      @(posedge clk_i) #1;
      cmp(host_rdata_o, m.exists(i) ? m[i] : 8'h00);
   endtask : rd

   // Lines counted over two successive half periods
   task alt(input logic [7:0] h);
      int n;
      logic p;
      p = alternation_blank_pin_o;
      // Sampled mid-cycle so the registered pin has settled
      repeat (3000) begin
         @(negedge clk_i);
         if (alternation_blank_pin_o !== p) break;
      end
      repeat (2) begin
         p = alternation_blank_pin_o;
         n = 0;
         repeat (3000) begin
            @(negedge clk_i);
            n += int'(line_stb_i);
            if (alternation_blank_pin_o !== p) break;
         end
         cmp(n[7:0], h);
      end
      @(posedge clk_i) #1;
   endtask : alt

   task pins(input logic [7:0] c);
      logic h, s, l, r, p, b, o;
      logic [7:0] d;
      @(posedge clk_i);
      {h, s, l, r, p, b, d} = {hsync_i, vsync_i, line_pulse_i, frame_pulse_i, pclk_i, blank_i,
                              video_pixel_bus_i};
      o = c[4] & crt_only_i;
      #1;
      cmp({2'h0, bo_w, hsync_o, vsync_o, line_pulse_o, frame_pulse_o, pclk_pin_o},
          {2'h0, b & !o, h & !c[3], s & !c[3], c[5] ? h : l, c[5] ? s : r, p & !c[4]});
      cmp(vo_w, o ? 8'h00 : d);
   endtask : pins

   task stop_test;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   initial begin
      #300us;
      mismatches++;
      stop_test();
   end

   initial begin
      {host_wr_i, host_sel_data_i, host_wdata_i, crt_wr_i, crt_wr_index_i, ln} = '0;
      {hsync_i, vsync_i, line_pulse_i, frame_pulse_i, pclk_i, blank_i} = '0;
      {line_stb_i, video_pixel_bus_i, crt_only_i} = '0;
      {alt_on_pin_en_i, panel_color_i, text_400_i, vexp_sel_i} = 5'h1d;
      sys_rst_i = 1'b1;
      void'($urandom(83));
      m[8'h24] = 8'h3c;
      m[8'h27] = 8'h00;
      m[8'h29] = 8'h00;
      m[8'h33] = 8'h00;
      repeat (5) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      foreach (m[i]) rd(i);
      rd(8'h25);
      alt(8'd120);
      // Divisor never zero and reserved feature bits kept clear
      foreach (m[i]) rw(i, 8'($urandom) & (i == 8'h29 ? 8'hfc : 8'hff) | 8'(i == 8'h24));
      foreach (m[i]) rd(i);
      foreach (lk[j]) begin
         rw(8'h27, lk[j]);
         cmp({4'h0, vs_w, enh_vexp_o}, {4'h0, vexp_sel_i, lk[j][0] ? lk[j][1:0] : 2'h0});
         foreach (ci[k]) begin
            crt_wr_i <= 1'b1;
            crt_wr_index_i <= ci[k];
            #1;
            cmp({7'h0, crt_wr_en_o}, {7'h0, k == 0 ? !lk[j][4] : k == 1 ? !lk[j][6] : 1'b1});
            if (k == 2) cmp(crt_wr_bits_o, lk[j][6] ? OVF_LOCK_BITS ^ 8'hff : 8'hff);
            @(posedge clk_i) #1;
         end
         crt_wr_i <= 1'b0;
      end
      text_400_i <= 1'b0;
      repeat (2) @(posedge clk_i) #1;
      cmp({6'h0, enh_vexp_o}, 8'h00);
      foreach (fv[j]) begin
         rw(8'h29, fv[j]);
         repeat (4) begin
            pins(fv[j]);
            crt_only_i <= ~crt_only_i;
         end
      end
      rw(8'h29, 8'h80);
      cmp({5'h0, pclk_pin_oe_n_o, blank_pin_oe_n_o, video_pixel_pins_oe_n_o}, 8'h07);
      repeat (4) begin
         v = 8'($urandom);
         f = 8'($urandom) & 8'h44;
         rw(8'h33, v);
         rw(8'h29, f);
         cmp({2'h0, panel_res_o, stn_type_o, tft_dither_sel_o},
             {2'h0, v[7], v[4], v[6:5], f[6], f[2]});
         cmp({3'h0, ro_w, lcd_4bit_o, shade_pwm_o, refresh_per_line_o},
             {3'h0, v[0], v[3], v[2], v[0] ? (v[1] ? 2'h2 : 2'h1) : 2'h0});
      end
      v = 8'(2 + $urandom % 6);
      rw(8'h24, v);
      alt(v << 1);
      panel_color_i <= 1'b0;
      alt(8'd240);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
